// >>> src/addr_map_pkg.sv
// shared constants and types for the cpu address map decoder
package addr_map_pkg;
    localparam int PHYS_W = 26;
    localparam int ADDR_W = 32;
    // physical map, 26-bit addresses
    localparam logic [25:0] ROM_AREA_LAST = 26'h00FFFFF;
    localparam logic [25:0] ROM_64K_LAST = 26'h000FFFF;
    localparam logic [25:0] ROM_128K_LAST = 26'h001FFFF;
    localparam logic [25:0] ALIAS_BASE = 26'h3FEF000;
    localparam logic [25:0] ALIAS_LAST = 26'h3FEFFFF;
    localparam logic [25:0] RAM_AREA_BASE = 26'h3FF0000;
    localparam logic [25:0] RAM_PHYS_BASE = 26'h3FFD800;
    localparam logic [25:0] PIO_BASE = 26'h3FFF000;
    // reset value of the program counter
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    // distance of the speculative fetch ahead of the program counter
    localparam logic [25:0] PREFETCH_STEP = 26'h0000004;
    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} size_t;
    typedef enum logic [1:0] {TGT_NONE, TGT_ROM, TGT_RAM, TGT_PIO} target_t;
    typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_PIO_LO, ST_PIO_HI} state_t;
endpackage

// >>> src/cpu_address_map_decoder.sv
// address map decoder with program and data wraparound
// Summary of operation
// R1: data space mirrors one 64 MB space
// R2: program counter upper 6 bits stay zero
// R3: program addresses wrap top to zero
// R4: operand address carry beyond 32 dropped
// R5: peripheral area decoded, never fetched from
// R6: lowest 1 MB goes to ROM area
// R7: 64 KB variant, ROM above prohibited
// R8: 128 KB variant, ROM above prohibited
// R9: RAM area ends below peripheral area
// R10: only top 6 KB of RAM usable
// R11: alias window below RAM not used
// R12: word peripheral access split, low half first
// R13: byte register: upper undefined, lower written
// R14: data address sign-extends bit 25
// R15: no prefetch into peripheral area
// R16: prohibited access: read zero, write ignored
`timescale 1ns/1ps
`default_nettype none
module cpu_address_map_decoder
    import addr_map_pkg::*;
#(
    parameter logic [25:0] ROM_LAST = addr_map_pkg::ROM_64K_LAST
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // program counter
    input wire logic pc_update,
    input wire logic [31:0] pc_delta,
    output logic [31:0] program_counter,
    output logic fetch_rom,
    output logic fetch_ram,
    output logic fetch_fault,
    output logic prefetch_ok,
    // operand access request
    input wire logic op_req,
    input wire logic [31:0] op_base,
    input wire logic [31:0] op_disp,
    input wire logic op_write,
    input wire addr_map_pkg::size_t op_size,
    input wire logic [31:0] op_wdata,
    output logic op_busy,
    output logic op_done,
    output logic [31:0] op_rdata,
    output logic [31:0] op_addr,
    // internal rom and ram
    output logic mem_rom_sel,
    output logic mem_ram_sel,
    output logic mem_we,
    output logic [25:0] mem_addr,
    output logic [31:0] mem_wdata,
    output addr_map_pkg::size_t mem_size,
    input wire logic [31:0] mem_rdata,
    // peripheral registers, halfword wide
    output logic pio_req,
    output logic pio_we,
    output logic [25:0] pio_addr,
    output logic [15:0] pio_wdata,
    output logic [1:0] pio_wmask,
    input wire logic pio_byte_reg,
    input wire logic [15:0] pio_rdata
);
    import addr_map_pkg::*;

    state_t state;
    logic [25:0] a_phys;
    size_t a_size;
    logic a_we;
    logic [31:0] a_wdata;
    target_t a_tgt;
    logic [15:0] lo_half;

    // map a physical address onto a target; holes give none
    function automatic target_t classify(input logic [25:0] a);
        target_t t;
        t = TGT_NONE;
        // R6 R7 R8 rom up to the variant's last byte
        if (a <= ROM_LAST) begin
            t = TGT_ROM;
            // R9 R10 R11 usable ram only, alias and low part refused
        end else if (a >= RAM_PHYS_BASE && a < PIO_BASE) begin
            t = TGT_RAM;
        end else if (a >= PIO_BASE) begin
            t = TGT_PIO;
        end
        return t;
    endfunction

    // R2 upper bits forced zero, carry out of bit 25 lost
    wire logic [25:0] next_pc_low = program_counter[25:0] + pc_delta[25:0];
    wire logic [31:0] next_pc = {6'h00, next_pc_low};
    // R5 peripheral area and holes are not fetchable
    wire target_t fetch_tgt = classify(program_counter[25:0]);
    wire logic [25:0] pf_addr = program_counter[25:0] + PREFETCH_STEP;
    wire target_t pf_tgt = classify(pf_addr);
    assign fetch_rom = fetch_tgt == TGT_ROM;
    assign fetch_ram = fetch_tgt == TGT_RAM;
    assign fetch_fault = !fetch_rom && !fetch_ram;
    // R15 a prefetch past RAM top would hit registers, so block it
    assign prefetch_ok = pf_tgt == TGT_ROM || pf_tgt == TGT_RAM;

    // R3 program counter wraps within 26 bits
    always_ff @(posedge clk) begin
        if (rst) begin
            program_counter <= PC_RESET;
        end else if (pc_update) begin
            program_counter <= next_pc;
        end
    end

    // R4 operand sum kept to 32 bits; R1 only low 26 bits decode
    wire logic [31:0] op_sum = op_base + op_disp;
    wire logic [25:0] op_phys = op_sum[25:0];
    wire target_t op_tgt = classify(op_phys);
    wire logic accept = state == ST_IDLE && op_req;
    assign op_busy = state != ST_IDLE;

    // access sequencer
    state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (op_req) begin
                    next_state = op_tgt == TGT_PIO ? ST_PIO_LO : ST_MEM;
                end
            end
            ST_MEM: begin
                next_state = ST_IDLE;
            end
            ST_PIO_LO: begin
                next_state = a_size == SZ_WORD ? ST_PIO_HI : ST_IDLE;
            end
            ST_PIO_HI: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // latch the request; R14 data address sign-extends bit 25
    always_ff @(posedge clk) begin
        if (rst) begin
            a_phys <= 26'h0000000;
            a_size <= SZ_BYTE;
            a_we <= 1'b0;
            a_wdata <= 32'h0000_0000;
            a_tgt <= TGT_NONE;
            op_addr <= 32'h0000_0000;
        end else if (accept) begin
            a_phys <= op_phys;
            a_size <= op_size;
            a_we <= op_write;
            a_wdata <= op_wdata;
            a_tgt <= op_tgt;
            op_addr <= {{6{op_phys[25]}}, op_phys};
        end
    end

    // R16 no select and no write strobe for a hole
    assign mem_rom_sel = state == ST_MEM && a_tgt == TGT_ROM;
    assign mem_ram_sel = state == ST_MEM && a_tgt == TGT_RAM;
    assign mem_we = (mem_rom_sel || mem_ram_sel) && a_we;
    assign mem_addr = a_phys;
    assign mem_wdata = a_wdata;
    assign mem_size = a_size;

    // R12 word goes as two halfwords, address bits 1:0 dropped
    wire logic hi_phase = state == ST_PIO_HI;
    wire logic half_sel = a_size == SZ_WORD ? hi_phase : a_phys[1];
    assign pio_req = state == ST_PIO_LO || hi_phase;
    assign pio_we = pio_req && a_we;
    assign pio_addr = {a_phys[25:2], half_sel, 1'b0};
    wire logic [15:0] byte_rep = {a_wdata[7:0], a_wdata[7:0]};
    assign pio_wdata = a_size == SZ_BYTE ? byte_rep
        : (hi_phase ? a_wdata[31:16] : a_wdata[15:0]);
    // R13 wide write to a byte register lands in the low lane only
    wire logic [1:0] byte_lane = a_phys[0] ? 2'b10 : 2'b01;
    assign pio_wmask = !pio_we ? 2'b00
        : (a_size == SZ_BYTE ? byte_lane
        : (pio_byte_reg ? 2'b01 : 2'b11));

    // R13 upper byte of a byte register reads as zero in halfword and word reads
    wire logic [15:0] pio_half = pio_byte_reg ? {8'h00, pio_rdata[7:0]}
        : pio_rdata;
    wire logic [7:0] pio_byte = a_phys[0] ? pio_rdata[15:8]
        : pio_rdata[7:0];

    // read data assembly; R16 holes read as zero
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (state == ST_MEM && a_tgt != TGT_NONE && !a_we) begin
            next_rdata = mem_rdata;
        end else if (state == ST_PIO_LO && !a_we) begin
            if (a_size == SZ_BYTE) begin
                next_rdata = {24'h000000, pio_byte};
            end else begin
                next_rdata = {16'h0000, pio_half};
            end
        end else if (hi_phase && !a_we) begin
            next_rdata = {pio_half, lo_half};
        end
    end

    wire logic finish = next_state == ST_IDLE && state != ST_IDLE;

    // data held until the next access completes
    always_ff @(posedge clk) begin
        if (rst) begin
            lo_half <= 16'h0000;
            op_done <= 1'b0;
            op_rdata <= 32'h0000_0000;
        end else begin
            op_done <= finish;
            if (state == ST_PIO_LO) begin
                lo_half <= pio_half;
            end
            if (finish) begin
                op_rdata <= next_rdata;
            end
        end
    end

    // checks
    sequence s_word_pio_start;
        accept && op_tgt == TGT_PIO && op_size == SZ_WORD;
    endsequence
    sequence s_two_halves;
        pio_req && !pio_addr[1] ##1 pio_req && pio_addr[1] ##1 op_done;
    endsequence
    sequence s_hole_start;
        accept && op_tgt == TGT_NONE && !op_write;
    endsequence

    chk_pc_wrap: assert property (@(posedge clk) disable iff (rst) // R3
        pc_update |=> program_counter ==
            {6'h00, $past(program_counter[25:0]) + $past(pc_delta[25:0])})
        else $error("program counter did not wrap in 26 bits");
    chk_pc_upper_zero: assert property (@(posedge clk) disable iff (rst) // R2
        program_counter[31:26] == 6'h00)
        else $error("program counter upper bits not zero");
    chk_pio_no_fetch: assert property (@(posedge clk) disable iff (rst) // R5
        program_counter[25:0] >= PIO_BASE |-> fetch_fault && !fetch_ram)
        else $error("fetch allowed from peripheral area");
    chk_prefetch_block: assert property (@(posedge clk) disable iff (rst) // R15
        pf_addr >= PIO_BASE |-> !prefetch_ok)
        else $error("prefetch into peripheral area");
    chk_word_split: assert property (@(posedge clk) disable iff (rst) // R12
        s_word_pio_start |=> s_two_halves)
        else $error("word peripheral access not split low then high");
    chk_byte_mask: assert property (@(posedge clk) disable iff (rst) // R13
        pio_we && pio_byte_reg && a_size != SZ_BYTE |-> pio_wmask == 2'b01)
        else $error("byte register written beyond low byte");
    chk_hole_read_zero: assert property (@(posedge clk) disable iff (rst) // R16
        s_hole_start |=> ##1 op_done && op_rdata == 32'h0000_0000)
        else $error("prohibited read did not return zero");
    chk_hole_no_write: assert property (@(posedge clk) disable iff (rst) // R16
        state == ST_MEM && a_tgt == TGT_NONE |-> !mem_we && !mem_ram_sel)
        else $error("prohibited address reached memory");
    chk_data_mirror: assert property (@(posedge clk) disable iff (rst) // R14
        accept |=> op_addr == {{6{a_phys[25]}}, a_phys}
            && a_phys == $past(op_base[25:0]) + $past(op_disp[25:0]))
        else $error("data address not mirrored and sign extended");
    chk_rom_route: assert property (@(posedge clk) disable iff (rst) // R6
        accept && op_phys <= ROM_LAST |=> a_tgt == TGT_ROM)
        else $error("low address not routed to ROM");
    chk_rom_limit: assert property (@(posedge clk) disable iff (rst) // R7
        accept && op_phys > ROM_LAST && op_phys <= ROM_AREA_LAST
            |=> a_tgt == TGT_NONE)
        else $error("address above ROM not refused");
    chk_alias_hole: assert property (@(posedge clk) disable iff (rst) // R11
        accept && op_phys >= ALIAS_BASE && op_phys < RAM_PHYS_BASE
            |=> a_tgt == TGT_NONE)
        else $error("alias window or low RAM area decoded");
endmodule
`default_nettype wire

// >>> bench/far_side_model.sv
// memory and peripheral responder on the far side of the decoder
`timescale 1ns/1ps
`default_nettype none
module far_side_model
    import addr_map_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // internal memory
    input wire logic mem_rom_sel,
    input wire logic mem_ram_sel,
    input wire logic [25:0] mem_addr,
    output logic [31:0] mem_rdata,
    // peripheral registers
    input wire logic pio_req,
    input wire logic [25:0] pio_addr,
    input wire logic byte_mode,
    output logic pio_byte_reg,
    output logic [15:0] pio_rdata
);
    logic [31:0] noise;
    // unselected lines churn so a stale value can never pass as data
    always_ff @(posedge clk) begin
        if (rst) begin
            noise <= 32'hC3C3_3C3C;
        end else begin
            noise <= {noise[0], noise[31:1]} ^ 32'h0000_0001;
        end
    end
    // data carries its own address so a wrong target shows up
    assign mem_rdata = (mem_rom_sel | mem_ram_sel) ? {6'h15, mem_addr} : noise;
    assign pio_rdata = pio_req ? {4'hB, pio_addr[11:0]} : noise[15:0];
    assign pio_byte_reg = pio_req ? byte_mode : noise[0];
endmodule
`default_nettype wire

// >>> bench/tb_cpu_address_map_decoder.sv
// self-checking bench for the address map decoder
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_address_map_decoder;
    import addr_map_pkg::*;
    logic clk, rst, pc_update, op_req, op_write, byte_mode, fetch_rom;
    logic fetch_ram, fetch_fault, prefetch_ok, op_busy, op_done, mem_we;
    logic mem_rom_sel, mem_ram_sel, pio_req, pio_we, pio_byte_reg;
    logic [31:0] pc_delta, op_base, op_disp, op_wdata, program_counter;
    logic [31:0] op_rdata, op_addr, mem_wdata, mem_rdata;
    logic [25:0] mem_addr, pio_addr;
    logic [15:0] pio_wdata, pio_rdata;
    logic [1:0] pio_wmask, tgt;
    logic [17:0] wlo, whi;
    logic [31:0] rd, mwd;
    logic [4:0] ctl;
    logic fetch_rom_wide;
    size_t op_size, mem_size;
    int n_errors, comparisons, lat;
    cpu_address_map_decoder uut (.clk, .rst, .pc_update, .pc_delta,
        .program_counter, .fetch_rom, .fetch_ram, .fetch_fault, .prefetch_ok,
        .op_req, .op_base, .op_disp, .op_write, .op_size, .op_wdata, .op_busy,
        .op_done, .op_rdata, .op_addr, .mem_rom_sel, .mem_ram_sel, .mem_we,
        .mem_addr, .mem_wdata, .mem_size, .mem_rdata, .pio_req, .pio_we,
        .pio_addr, .pio_wdata, .pio_wmask, .pio_byte_reg, .pio_rdata);
    far_side_model far (.clk, .rst, .mem_rom_sel, .mem_ram_sel, .mem_addr,
        .mem_rdata, .pio_req, .pio_addr, .byte_mode, .pio_byte_reg,
        .pio_rdata);
    // larger rom build; only its fetch decode is judged
    cpu_address_map_decoder #(.ROM_LAST(ROM_128K_LAST)) uut_wide (.clk,
        .rst, .pc_update, .pc_delta, .program_counter(),
        .fetch_rom(fetch_rom_wide), .fetch_ram(), .fetch_fault(),
        .prefetch_ok(), .op_req, .op_base, .op_disp, .op_write, .op_size,
        .op_wdata, .op_busy(), .op_done(), .op_rdata(), .op_addr(),
        .mem_rom_sel(), .mem_ram_sel(), .mem_we(), .mem_addr(),
        .mem_wdata(), .mem_size(), .mem_rdata, .pio_req(), .pio_we(),
        .pio_addr(), .pio_wdata(), .pio_wmask(), .pio_byte_reg,
        .pio_rdata);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one operand access; a hung answer ends the run
    task automatic acc(input logic [31:0] b, input logic [31:0] d,
                       input logic w, input size_t s, input logic [31:0] wd);
        op_base = b;
        op_disp = d;
        op_write = w;
        op_size = s;
        op_wdata = wd;
        op_req = 1'b1;
        @(posedge clk);
        #1 op_req = 1'b0;
        lat = 1;
        tgt = {mem_ram_sel | pio_req, mem_rom_sel | pio_req};
        wlo = {pio_wmask, pio_wdata};
        ctl = {op_busy, mem_we, pio_we, mem_size};
        mwd = mem_wdata;
        do begin
            @(posedge clk);
            #1 lat++;
            // second cycle carries the upper half of a split access
            if (lat == 2) begin
                whi = {pio_addr[1:0], pio_wdata};
            end
        end while (op_done !== 1'b1 && lat < 6);
        if (lat == 6) begin
            n_errors++;
            test_done();
        end
        rd = op_rdata;
    endtask
    task automatic pc_step(input logic [31:0] d);
        pc_update = 1'b1;
        pc_delta = d;
        @(posedge clk);
        #1 pc_update = 1'b0;
        // idle edge so back-to-back steps never re-raise the strobe
        @(posedge clk);
        #1;
    endtask
    task automatic scen_pc();
        check(program_counter, 32'h0);
        check(fetch_rom, 1'b1);
        pc_step(32'hFFFF_FFFC);
        check(program_counter, 32'h03FF_FFFC);
        check({fetch_fault, fetch_rom, fetch_ram}, 3'b100);
        pc_step(32'h0000_0008);
        check(program_counter, 32'h0000_0004);
        pc_step(32'h03FF_EFF8);
        check({fetch_ram, prefetch_ok}, 2'b10);
        pc_step(32'hFFFF_FFFC);
        check(prefetch_ok, 1'b1);
        pc_step(32'hFC00_0000);
        check(program_counter, 32'h03FF_EFF8);
        pc_step(32'h0002_1004);
        check({fetch_rom_wide, fetch_rom, fetch_fault}, 3'b101);
        pc_step(32'h0000_0004);
        check(fetch_rom_wide, 1'b0);
    endtask
    // back-to-back reads over mirrors, edges and prohibited holes
    task automatic scen_map();
        logic [31:0] ab[9] = '{32'hFC00_0100, 32'h0000_FFFC, 32'h0001_0000,
            32'h03FF_D800, 32'hFFFF_EFFC, 32'h03FF_D7FC, 32'h03FE_F000,
            32'h03FF_0000, 32'hFFFF_FFFF};
        logic [31:0] er[9] = '{32'h5400_0100, 32'h5400_FFFC, 32'h0,
            32'h57FF_D800, 32'h57FF_EFFC, 32'h0, 32'h0, 32'h0,
            32'h5400_0100};
        logic [1:0] et[9] = '{2'd1, 2'd1, 2'd0, 2'd2, 2'd2, 2'd0, 2'd0, 2'd0,
            2'd1};
        logic [31:0] a;
        for (int i = 0; i < 9; i++) begin
            acc(ab[i], (i == 8) ? 32'h101 : 32'h0, 1'b0, SZ_WORD, 32'h0);
            a = ab[i] + ((i == 8) ? 32'h101 : 32'h0);
            check(op_addr, {{6{a[25]}}, a[25:0]});
            check(tgt, et[i]);
            check(rd, er[i]);
            check(lat, 2);
            check(ctl, 5'h12);
        end
        // writes: memory strobe for usable ram, none for a hole
        acc(32'hFFFF_D800, 32'h0, 1'b1, SZ_HALF, 32'hDEAD_BEEF);
        check({tgt, ctl}, 7'h59);
        check(mwd, 32'hDEAD_BEEF);
        check(rd, 32'h0);
        acc(32'h0001_0000, 32'h0, 1'b1, SZ_WORD, 32'hDEAD_BEEF);
        check({tgt, ctl}, 7'h12);
    endtask
    task automatic scen_pio();
        acc(32'hFFFF_F013, 32'h0, 1'b0, SZ_WORD, 32'h0);
        check({tgt, lat[3:0]}, 6'h33);
        check(rd, 32'hB012_B010);
        acc(32'h03FF_F020, 32'h0, 1'b1, SZ_WORD, 32'h1234_5678);
        check(wlo, {2'b11, 16'h5678});
        check(lat, 3);
        check(whi, {2'b10, 16'h1234});
        acc(32'h03FF_F031, 32'h0, 1'b0, SZ_BYTE, 32'h0);
        check(rd, 32'h0000_00B0);
        acc(32'h03FF_F031, 32'h0, 1'b1, SZ_BYTE, 32'h0000_005A);
        check(wlo, {2'b10, 16'h5A5A});
        byte_mode = 1'b1;
        acc(32'h03FF_F030, 32'h0, 1'b0, SZ_HALF, 32'h0);
        check(rd, 32'h0000_0030);
        acc(32'h03FF_F030, 32'h0, 1'b1, SZ_HALF, 32'h0000_ABCD);
        check(wlo, {2'b01, 16'hABCD});
        byte_mode = 1'b0;
    endtask
    initial begin
        {rst, pc_update, op_req, op_write, byte_mode} = 5'b10000;
        {pc_delta, op_base, op_disp, op_wdata} = '0;
        op_size = SZ_WORD;
        n_errors = 0;
        comparisons = 0;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        scen_pc();
        scen_map();
        scen_pio();
        test_done();
    end
endmodule
`default_nettype wire
